// ---- hdl/lp_clock_ctrl.sv ----
// low-power mode sequencer, clock gating, serial scaling, core and
// missing-clock watchdogs. assumes the cpu raises idle_exec for one
// cycle on its idle instruction; pins gpio_wake, ext_irq and
// osc_beat are asynchronous and are synchronised here.
`timescale 1ns/1ps
// Summary of operation
// - unserviced watchdog resets the processor
// - software bit disables watchdog resets
// - clock failure gives interrupt or reset
// - per-peripheral clock enable bits
// - serial clock scaled, i2c never scaled
// - idle stops cpu, interrupt from a clock-enabled peripheral wakes
// - standby gates cpu and peripherals, pll runs
// - external interrupt wakes standby after the two-flop synchroniser
// - halt stops internal oscillators unless kept
// - kept oscillator still clocks the watchdog
// - halt stops selected crystal oscillator
// - reset, gpio or watchdog leaves halt
// - gpio pins wake standby and halt
module lp_clock_ctrl
  import lpc_pkg::*;
#(
  parameter int WD_LIMIT = WD_CYCLES
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata_r,
  // cpu and wake sources
  input wire logic idle_exec,
  input wire logic [NPERIPH-1:0] periph_irq,
  input wire logic ext_irq,
  input wire logic gpio_wake,
  input wire logic osc_beat,
  // clock gates
  output logic cpu_clk_en_r,
  output logic [NPERIPH-1:0] periph_clk_en_r,
  output logic serial_tick_r,
  output logic i2c_clk_en_r,
  // oscillators
  output logic [1:0] int_osc_en_r,
  output logic xtal_en_r,
  output logic pll_en_r,
  // reset and interrupt
  output logic cpu_reset_r,
  output logic irq_r
);
  pwr_state_t st_r, st_nxt;
  logic [1:0] lpm_r, lpm_nxt;
  logic [5:0] clksrc_r, clksrc_nxt;
  logic [NPERIPH-1:0] pclk_r, pclk_nxt;
  logic [2:0] scale_r, scale_nxt;
  logic [2:0] wdctl_r, wdctl_nxt;
  logic key_arm_r, key_arm_nxt;
  logic [IRQ_W-1:0] istat_r, istat_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic [15:0] rdata_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic [7:0] miss_cnt_r, miss_cnt_nxt;
  logic [3:0] rst_cnt_r, rst_cnt_nxt;
  logic beat_prev_r;
  logic [2:0] sync1_r, sync2_r;
  logic gpio_s, ext_s, beat_s;
  logic wd_restart, wd_expire, wd_runs, miss_fail, osc_should_run;
  logic wake_any, wake_idle, wake_stby, wake_halt;
  logic [1:0] keep;
  logic [1:0] src;
  logic [1:0] wd_src;
  logic stat_rd;
  logic sc_tick;

  // two-flop synchronisers for the asynchronous pins
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {osc_beat, ext_irq, gpio_wake};
      sync2_r <= sync1_r;
    end
  end
  assign gpio_s = sync2_r[0];
  assign ext_s = sync2_r[1];
  assign beat_s = sync2_r[2];

  // field views
  assign keep = {clksrc_r[KEEP2_BIT], clksrc_r[KEEP1_BIT]};
  assign src = clksrc_r[SRC_LSB+1:SRC_LSB];
  assign wd_src = clksrc_r[WDSRC_LSB+1:WDSRC_LSB];

  // watchdog counts except in halt when clocked from the crystal or an unkept internal oscillator
  always_comb begin
    wd_runs = 1'b1;
    if (st_r == ST_HALT) begin
      case (wd_src)
        SRC_INTOSC1: wd_runs = keep[0];
        SRC_INTOSC2: wd_runs = keep[1];
        SRC_XTAL: wd_runs = 1'b0;
        default: wd_runs = 1'b1;
      endcase
    end
  end

  // watchdog restart by key pair, expiry at the window end
  assign wd_restart = wr_en && (addr == OFS_WDKEY) && key_arm_r && (wdata[7:0] == WD_KEY2);
  assign wd_expire = !wdctl_r[WD_DIS_BIT] && wd_runs && (wd_cnt_r >= WD_LIMIT - 1);

  // missing clock: oscillator expected to beat outside halt
  assign osc_should_run = (st_r != ST_HALT);
  assign miss_fail = osc_should_run && (miss_cnt_r == 8'(MISS_CYCLES));

  // wake conditions per mode
  assign wake_idle = |(periph_irq & pclk_r) || (wd_expire && wdctl_r[WD_IRQ_BIT]);
  assign wake_stby = ext_s || gpio_s;
  assign wake_halt = gpio_s || wd_expire;
  assign stat_rd = rd_en && (addr == OFS_ISTAT);

  // power state sequencer
  always_comb begin
    st_nxt = st_r;
    wake_any = 1'b0;
    case (st_r)
      ST_RUN: begin
        if (idle_exec) begin
          case (lpm_r)
            2'h1: st_nxt = ST_STANDBY;
            2'h2: st_nxt = ST_HALT;
            default: st_nxt = ST_IDLE;
          endcase
        end
      end
      ST_IDLE: begin
        if (wake_idle) begin
          st_nxt = ST_RUN;
          wake_any = 1'b1;
        end
      end
      ST_STANDBY: begin
        if (wake_stby) begin
          st_nxt = ST_RUN;
          wake_any = 1'b1;
        end
      end
      ST_HALT: begin
        if (wake_halt) begin
          st_nxt = ST_RUN;
          wake_any = 1'b1;
        end
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  // register writes
  always_comb begin
    lpm_nxt = lpm_r;
    clksrc_nxt = clksrc_r;
    pclk_nxt = pclk_r;
    scale_nxt = scale_r;
    wdctl_nxt = wdctl_r;
    imask_nxt = imask_r;
    key_arm_nxt = key_arm_r;
    if (wr_en) begin
      case (addr)
        OFS_LPM: lpm_nxt = wdata[1:0];
        OFS_CLKSRC: clksrc_nxt = wdata[5:0];
        OFS_PCLK: pclk_nxt = wdata[NPERIPH-1:0];
        OFS_SCALE: scale_nxt = wdata[2:0];
        OFS_WDCTL: wdctl_nxt = wdata[2:0];
        OFS_IMASK: imask_nxt = wdata[IRQ_W-1:0];
        OFS_WDKEY: key_arm_nxt = (wdata[7:0] == WD_KEY1);
        default: begin
        end
      endcase
    end
  end

  // counters: watchdog, missing clock, reset pulse
  always_comb begin
    wd_cnt_nxt = wd_cnt_r;
    if (wd_restart || wdctl_r[WD_DIS_BIT] || wd_expire) begin
      wd_cnt_nxt = 32'h0;
    end else if (wd_runs) begin
      wd_cnt_nxt = wd_cnt_r + 32'h1;
    end
    miss_cnt_nxt = miss_cnt_r;
    if (!osc_should_run || (beat_s != beat_prev_r) || miss_fail) begin
      miss_cnt_nxt = 8'h0;
    end else begin
      miss_cnt_nxt = miss_cnt_r + 8'h1;
    end
    rst_cnt_nxt = (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 : 4'h0;
    if ((wd_expire && !wdctl_r[WD_IRQ_BIT]) || (miss_fail && wdctl_r[MC_RST_BIT])) begin
      rst_cnt_nxt = 4'(RST_CYCLES);
    end
  end

  // sticky status, cleared by a read, a new event wins
  always_comb begin
    istat_nxt = stat_rd ? '0 : istat_r;
    if (miss_fail && !wdctl_r[MC_RST_BIT]) begin
      istat_nxt[IRQ_MCLK] = 1'b1;
    end
    if (wd_expire && wdctl_r[WD_IRQ_BIT]) begin
      istat_nxt[IRQ_WD] = 1'b1;
    end
    if (wake_any) begin
      istat_nxt[IRQ_WAKE] = 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_en) begin
      case (addr)
        OFS_LPM: rdata_nxt = {14'h0, lpm_r};
        OFS_CLKSRC: rdata_nxt = {10'h0, clksrc_r};
        OFS_PCLK: rdata_nxt = {8'h0, pclk_r};
        OFS_SCALE: rdata_nxt = {13'h0, scale_r};
        OFS_WDCTL: rdata_nxt = {13'h0, wdctl_r};
        OFS_ISTAT: rdata_nxt = {13'h0, istat_r};
        OFS_IMASK: rdata_nxt = {13'h0, imask_r};
        OFS_STATE: rdata_nxt = {wd_cnt_r[31:18], st_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // state and register flops
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_r <= ST_RUN;
      lpm_r <= 2'h0;
      clksrc_r <= CLKSRC_RST;
      pclk_r <= PCLK_RST[NPERIPH-1:0];
      scale_r <= SCALE_RST;
      wdctl_r <= 3'h0;
      imask_r <= '0;
      key_arm_r <= 1'b0;
      istat_r <= '0;
      rdata_r <= 16'h0000;
      wd_cnt_r <= 32'h0;
      miss_cnt_r <= 8'h0;
      rst_cnt_r <= 4'h0;
      beat_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      lpm_r <= lpm_nxt;
      clksrc_r <= clksrc_nxt;
      pclk_r <= pclk_nxt;
      scale_r <= scale_nxt;
      wdctl_r <= wdctl_nxt;
      imask_r <= imask_nxt;
      key_arm_r <= key_arm_nxt;
      istat_r <= istat_nxt;
      rdata_r <= rdata_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      miss_cnt_r <= miss_cnt_nxt;
      rst_cnt_r <= rst_cnt_nxt;
      beat_prev_r <= beat_s;
    end
  end

  // serial clock scaler, runs only while peripherals are clocked
  serial_scaler i_serial_scaler (
    .mclk(mclk),
    .resetn(resetn),
    .run(st_nxt == ST_RUN || st_nxt == ST_IDLE),
    .div(scale_r),
    .tick_r(sc_tick)
  );

  // output gates, registered
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cpu_clk_en_r <= 1'b1;
      periph_clk_en_r <= '0;
      serial_tick_r <= 1'b0;
      i2c_clk_en_r <= 1'b0;
      int_osc_en_r <= 2'b11;
      xtal_en_r <= 1'b1;
      pll_en_r <= 1'b1;
      cpu_reset_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      cpu_clk_en_r <= (st_nxt == ST_RUN);
      if (st_nxt == ST_RUN || st_nxt == ST_IDLE) begin
        periph_clk_en_r <= pclk_nxt;
      end else begin
        periph_clk_en_r <= '0;
      end
      serial_tick_r <= sc_tick;
      i2c_clk_en_r <= (st_nxt == ST_RUN || st_nxt == ST_IDLE) && pclk_nxt[I2C_IDX];
      if (st_nxt == ST_HALT) begin
        int_osc_en_r <= {clksrc_nxt[KEEP2_BIT], clksrc_nxt[KEEP1_BIT]};
        xtal_en_r <= (clksrc_nxt[SRC_LSB+1:SRC_LSB] != SRC_XTAL);
        pll_en_r <= 1'b0;
      end else begin
        int_osc_en_r <= 2'b11;
        xtal_en_r <= 1'b1;
        pll_en_r <= 1'b1;
      end
      cpu_reset_r <= (rst_cnt_nxt != 4'h0);
      irq_r <= |(istat_nxt & imask_nxt);
    end
  end
endmodule

// ---- hdl/serial_scaler.sv ----
// serial port clock scaler: one-cycle enable pulse at mclk / ratio
// assumes div comes from a register on the same clock
`timescale 1ns/1ps
module serial_scaler
  import lpc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [2:0] div,
  // output
  output logic tick_r
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic tick_nxt;
  logic [3:0] period;

  // ratio 1 when div is zero, else 2*div
  always_comb begin
    period = (div == 3'h0) ? 4'h1 : {div, 1'b0};
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (run) begin
      if (cnt_r + 4'h1 >= period) begin
        cnt_nxt = 4'h0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1;
      end
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// ---- pkg/lpc_pkg.sv ----
// constants for the low-power, clock gating and watchdog control block
// assumes a 100 MHz mclk and a plain strobe register port
package lpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_LPM = 8'h00;
  localparam logic [7:0] OFS_CLKSRC = 8'h04;
  localparam logic [7:0] OFS_PCLK = 8'h08;
  localparam logic [7:0] OFS_SCALE = 8'h0C;
  localparam logic [7:0] OFS_WDCTL = 8'h10;
  localparam logic [7:0] OFS_WDKEY = 8'h14;
  localparam logic [7:0] OFS_ISTAT = 8'h18;
  localparam logic [7:0] OFS_IMASK = 8'h1C;
  localparam logic [7:0] OFS_STATE = 8'h20;
  // clock source control fields
  localparam int KEEP1_BIT = 0;
  localparam int KEEP2_BIT = 1;
  localparam int SRC_LSB = 2;
  localparam int WDSRC_LSB = 4;
  // clock sources
  localparam logic [1:0] SRC_INTOSC1 = 2'h0;
  localparam logic [1:0] SRC_INTOSC2 = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  // watchdog control fields
  localparam int WD_DIS_BIT = 0;
  localparam int WD_IRQ_BIT = 1;
  localparam int MC_RST_BIT = 2;
  // restart keys, first then second
  localparam logic [7:0] WD_KEY1 = 8'h55;
  localparam logic [7:0] WD_KEY2 = 8'hAA;
  // interrupt status bits
  localparam int IRQ_MCLK = 0;
  localparam int IRQ_WD = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W = 3;
  // peripheral clock enables, i2c has its own bit
  localparam int NPERIPH = 8;
  localparam int I2C_IDX = 7;
  // reset values
  localparam logic [15:0] PCLK_RST = 16'h0000;
  localparam logic [2:0] SCALE_RST = 3'h0;
  localparam logic [5:0] CLKSRC_RST = 6'h00;
  // timing: watchdog window and missing clock limit
  localparam int WD_TIMEOUT_US = 200;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int WD_CYCLES = WD_TIMEOUT_US * 1000 / MCLK_PERIOD_NS;
  localparam int MISS_TIME_NS = 400;
  localparam int MISS_CYCLES = MISS_TIME_NS / MCLK_PERIOD_NS;
  localparam int RST_PULSE_NS = 80;
  localparam int RST_CYCLES = (RST_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // power states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_STANDBY = 2'b10,
    ST_HALT = 2'b11
  } pwr_state_t;
endpackage

// ---- tb/lp_clock_ctrl_checker.sv ----
// port checker for lp_clock_ctrl
// bound to the design, sees its ports only
`timescale 1ns/1ps
module lp_clock_ctrl_checker
  import lpc_pkg::*;
#(
  parameter int WD_LIMIT = WD_CYCLES
)
(
  // clock, reset, register port
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [15:0] rdata_r,
  // wake sources
  input wire logic idle_exec,
  input wire logic [NPERIPH-1:0] periph_irq,
  input wire logic ext_irq,
  input wire logic gpio_wake,
  input wire logic osc_beat,
  // gates, oscillators, reset, interrupt
  input wire logic cpu_clk_en_r,
  input wire logic [NPERIPH-1:0] periph_clk_en_r,
  input wire logic serial_tick_r,
  input wire logic i2c_clk_en_r,
  input wire logic [1:0] int_osc_en_r,
  input wire logic xtal_en_r,
  input wire logic pll_en_r,
  input wire logic cpu_reset_r,
  input wire logic irq_r
);
  logic [1:0] lpm_r, lpm_nxt;
  logic [5:0] src_r, src_nxt;
  logic [2:0] mask_r, mask_nxt;
  // shadow copies of mode, source and mask registers
  always_comb begin
    lpm_nxt = lpm_r;
    src_nxt = src_r;
    mask_nxt = mask_r;
    if (wr_en && addr == OFS_LPM) lpm_nxt = wdata[1:0];
    if (wr_en && addr == OFS_CLKSRC) src_nxt = wdata[5:0];
    if (wr_en && addr == OFS_IMASK) mask_nxt = wdata[2:0];
    if (!resetn) begin
      lpm_nxt = 2'h0;
      src_nxt = CLKSRC_RST;
      mask_nxt = 3'h0;
    end
  end
  always_ff @(posedge mclk) begin
    lpm_r <= lpm_nxt;
    src_r <= src_nxt;
    mask_r <= mask_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // idle instruction taken while running in a given mode
  sequence s_enter(logic [1:0] m);
    idle_exec && cpu_clk_en_r && lpm_r == m;
  endsequence
  a_reset_pulse: assert property ($rose(cpu_reset_r) |-> cpu_reset_r [*8] ##1 !cpu_reset_r)
    else $error("cpu reset pulse not eight cycles");
  a_idle_stops: assert property (idle_exec && cpu_clk_en_r |=> !cpu_clk_en_r)
    else $error("cpu clock still on after idle instruction");
  a_idle_periph: assert property (s_enter(2'h0) |=> periph_clk_en_r == $past(periph_clk_en_r) && pll_en_r)
    else $error("idle changed peripheral clocks");
  a_standby_gates: assert property (s_enter(2'h1) |=> !cpu_clk_en_r && periph_clk_en_r == '0 && pll_en_r)
    else $error("standby gating wrong");
  a_halt_osc: assert property (s_enter(2'h2) |=> !pll_en_r && int_osc_en_r == src_r[1:0])
    else $error("halt oscillator enables wrong");
  a_halt_xtal: assert property (s_enter(2'h2) |=> xtal_en_r == (src_r[3:2] != SRC_XTAL))
    else $error("halt crystal enable wrong");
  a_wake_full: assert property ($rose(pll_en_r) |-> cpu_clk_en_r)
    else $error("halt left without cpu clock");
  a_irq_masked: assert property (irq_r |-> mask_r != 3'h0)
    else $error("interrupt with all sources masked");
  a_rdata_idle: assert property (rdata_r != 16'h0000 |-> $past(rd_en))
    else $error("read data without read strobe");
endmodule
bind lp_clock_ctrl lp_clock_ctrl_checker #(.WD_LIMIT(WD_LIMIT)) chk_inst (.mclk, .resetn, .addr, .wdata,
  .wr_en, .rd_en, .rdata_r, .idle_exec, .periph_irq, .ext_irq, .gpio_wake, .osc_beat, .cpu_clk_en_r,
  .periph_clk_en_r, .serial_tick_r, .i2c_clk_en_r, .int_osc_en_r, .xtal_en_r, .pll_en_r, .cpu_reset_r, .irq_r);

// ---- tb/test_lp_clock_ctrl.sv ----
// self-checking bench for lp_clock_ctrl
// drives every port itself; watchdog limit shortened to 50
`timescale 1ns/1ps
module test_lp_clock_ctrl
  import lpc_pkg::*;
;
  logic mclk = 0;
  logic resetn = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 0, rd_en = 0, idle_exec = 0, ext_irq = 0, gpio_wake = 0, osc_beat = 0, beat_on = 1;
  logic [7:0] periph_irq = 8'h00;
  logic [15:0] rdata_r, lf = 16'h000B;
  logic [7:0] periph_clk_en_r;
  logic [1:0] int_osc_en_r;
  logic cpu_clk_en_r, serial_tick_r, i2c_clk_en_r, xtal_en_r, pll_en_r, cpu_reset_r, irq_r;
  int err_count = 0, n_checks = 0, rst_hits = 0;
  lp_clock_ctrl #(.WD_LIMIT(50)) i_lp_clock_ctrl (.mclk, .resetn, .addr, .wdata, .wr_en, .rd_en,
    .rdata_r, .idle_exec, .periph_irq, .ext_irq, .gpio_wake, .osc_beat, .cpu_clk_en_r, .periph_clk_en_r,
    .serial_tick_r, .i2c_clk_en_r, .int_osc_en_r, .xtal_en_r, .pll_en_r, .cpu_reset_r, .irq_r);
  // clock, oscillator heartbeat, reset pulse count
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (beat_on) osc_beat <= ~osc_beat;
    if (cpu_reset_r) rst_hits++;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // window of cycles: eight scaler periods of 2*div, sixteen cycles (a tick every cycle) when div is 0
  function automatic int win(input logic [2:0] dv);
    return dv == 3'h0 ? 16 : 16 * dv;
  endfunction
  function automatic logic pick(input int s);
    return s == 0 ? cpu_clk_en_r : cpu_reset_r;
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata_r;
  endtask
  // bounded wait for cpu clock (0) or cpu reset (1) to rise
  task automatic wt(input int s, input int n);
    int c;
    c = 0;
    while (pick(s) !== 1'b1 && c < n) begin
      cyc(1);
      c++;
    end
    chk({15'h0, pick(s)}, 16'h0001);
  endtask
  task automatic ent(input logic [1:0] m);
    wr(OFS_LPM, {14'h0, m});
    @(posedge mclk);
    idle_exec <= 1'b1;
    @(posedge mclk);
    idle_exec <= 1'b0;
    cyc(2);
  endtask
  // main sequence
  initial begin
    logic [15:0] d;
    int c;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    cyc(1);
    chk({1'b0, cpu_clk_en_r, periph_clk_en_r, int_osc_en_r, xtal_en_r, pll_en_r, cpu_reset_r, irq_r}, 16'h403C);
    wr(OFS_WDCTL, 16'h0001);
    for (int i = 0; i < 5; i++) begin
      lf = nxt(lf);
      wr(OFS_PCLK, {8'h00, lf[7:0]});
      rd(OFS_PCLK, d);
      chk(d, {8'h00, lf[7:0]});
      chk({8'h00, periph_clk_en_r}, {8'h00, lf[7:0]});
      chk({15'h0, i2c_clk_en_r}, {15'h0, lf[7]});
      wr(OFS_SCALE, {13'h0, lf[10:8]});
      cyc(16);
      c = 0;
      repeat (win(lf[10:8])) begin
        cyc(1);
        c += serial_tick_r;
      end
      chk(c[15:0], lf[10:8] == 3'h0 ? 16'h0010 : 16'h0008);
    end
    wr(8'hFC, 16'hFFFF);
    rd(8'hFC, d);
    chk(d, 16'h0000);
    wr(OFS_PCLK, 16'h0001);
    for (int m = 0; m < 4; m += 3) begin
      ent(m[1:0]);
      periph_irq <= 8'h02;
      cyc(10);
      chk({15'h0, cpu_clk_en_r}, 16'h0000);
      periph_irq <= 8'h01;
      wt(0, 10);
      periph_irq <= 8'h00;
      rd(OFS_ISTAT, d);
      chk({d[14:0], irq_r}, 16'h0008);
    end
    wr(OFS_IMASK, 16'h0004);
    ent(2'h1);
    rd(OFS_STATE, d);
    chk(d & 16'h0003, 16'h0002);
    ext_irq <= 1'b1;
    wt(0, 10);
    ext_irq <= 1'b0;
    cyc(2);
    chk({15'h0, irq_r}, 16'h0001);
    rd(OFS_ISTAT, d);
    cyc(2);
    chk({d[14:0], irq_r}, 16'h0008);
    wr(OFS_CLKSRC, 16'h0029);
    ent(2'h2);
    chk({12'h0, int_osc_en_r, xtal_en_r, pll_en_r}, 16'h0004);
    gpio_wake <= 1'b1;
    wt(0, 10);
    gpio_wake <= 1'b0;
    wr(OFS_WDCTL, 16'h0002);
    wr(OFS_CLKSRC, 16'h0000);
    ent(2'h2);
    cyc(80);
    chk({15'h0, cpu_clk_en_r}, 16'h0000);
    gpio_wake <= 1'b1;
    wt(0, 10);
    gpio_wake <= 1'b0;
    wr(OFS_CLKSRC, 16'h0001);
    ent(2'h2);
    wt(0, 70);
    rd(OFS_ISTAT, d);
    chk(d & 16'h0002, 16'h0002);
    wr(OFS_WDCTL, 16'h0000);
    c = rst_hits;
    repeat (6) begin
      wr(OFS_WDKEY, {8'h00, WD_KEY1});
      wr(OFS_WDKEY, {8'h00, WD_KEY2});
      cyc(20);
    end
    chk(rst_hits[15:0], c[15:0]);
    wt(1, 60);
    c = rst_hits;
    wr(OFS_WDCTL, 16'h0001);
    cyc(120);
    chk(rst_hits[15:0], c[15:0] + 16'h0008);
    beat_on <= 1'b0;
    cyc(60);
    rd(OFS_ISTAT, d);
    chk(d, 16'h0001);
    beat_on <= 1'b1;
    cyc(8);
    wr(OFS_WDCTL, 16'h0005);
    beat_on <= 1'b0;
    wt(1, 60);
    beat_on <= 1'b1;
    cyc(10);
    results();
  end
  // hang guard
  initial begin
    repeat (10000) @(posedge mclk);
    err_count++;
    results();
  end
endmodule
